// ==== logic/vsbfc_pkg.sv ====
// Package: constants and types shared by both ends of the serial bridge link
package vsbfc_pkg;
    localparam int unsigned CLOCK_HZ      = 25000000;
    localparam int unsigned BAUD_DEFAULT  = 115200;
    localparam int unsigned BAUD_MIN      = 9600;
    localparam int unsigned BAUD_MAX      = 921600;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned DIV_W         = 16;
    // Cycles per bit, rounded down
    localparam logic [15:0] DIV_DEFAULT   = 16'(CLOCK_HZ / BAUD_DEFAULT);
    localparam logic [15:0] DIV_SLOWEST   = 16'(CLOCK_HZ / BAUD_MIN);
    localparam logic [15:0] DIV_FASTEST   = 16'(CLOCK_HZ / BAUD_MAX);

    // Handshake modes
    localparam logic [1:0] HS_DISABLED    = 2'h0;
    localparam logic [1:0] HS_RTS         = 2'h1;
    localparam logic [1:0] HS_CTS         = 2'h2;
    localparam logic [1:0] HS_RTSCTS      = 2'h3;

    // Register map of the bridge end
    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_DIV        = 4'h1;
    localparam logic [3:0] REG_STATUS     = 4'h2;
    localparam logic [3:0] REG_TXDATA     = 4'h3;
    localparam logic [3:0] REG_RXDATA     = 4'h4;
    localparam logic [3:0] REG_HOST       = 4'h5;

    localparam int unsigned CTRL_MODE_LO  = 0;
    localparam int unsigned CTRL_MODE_HI  = 1;
    localparam int unsigned CTRL_EN       = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    localparam int unsigned ST_TXBUSY     = 0;
    localparam int unsigned ST_TXFULL     = 1;
    localparam int unsigned ST_RXFULL     = 2;
    localparam int unsigned ST_PERMIT     = 3;
    localparam int unsigned ST_READY      = 4;
    localparam int unsigned ST_SOCKET     = 5;

    localparam logic [3:0] BIT_LAST       = 4'h9;
    localparam logic [3:0] BIT_ZERO       = 4'h0;

    typedef enum logic [3:0]
    {
        VSB_IDLE  = 4'b0001,
        VSB_START = 4'b0010,
        VSB_DATA  = 4'b0100,
        VSB_STOP  = 4'b1000
    } vsb_state_t;
endpackage : vsbfc_pkg

// ==== logic/vsbfc_link_if.sv ====
// Interface: serial data lines, flow-control lines and link enable
`timescale 1ns/100ps
interface vsbfc_link_if;
    logic targetTx;
    logic targetRx;
    logic sendPermitN;
    logic sendPermitOe;
    logic recvReadyN;
    logic linkEnable;
    // Open line reads high (deasserted) when the bridge does not drive it
    logic sendPermitLineN;
    assign sendPermitLineN = sendPermitOe ? sendPermitN : 1'b1;

    modport bridge
    (
        input  targetTx,
        output targetRx,
        output sendPermitN,
        output sendPermitOe,
        input  recvReadyN,
        input  linkEnable
    );
    modport target
    (
        output targetTx,
        input  targetRx,
        input  sendPermitLineN,
        output recvReadyN,
        output linkEnable
    );
endinterface : vsbfc_link_if

// ==== logic/vsbfc_bridge.sv ====
// Bridge end: board-controller UART with RTS/CTS handshake and register port
`timescale 1ns/100ps
module vsbfc_bridge
    import vsbfc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    vsbfc_link_if.bridge           link,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [15:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [15:0]       regRdata,
    input  wire logic              socketConnected
);
    // ==================================================================
    // Registers
    logic [2:0]       ctrl_q;
    logic [15:0]      div_q;
    logic [7:0]       txHold_q;
    logic             txFull_q;
    logic [7:0]       rxHold_q;
    logic             rxFull_q;
    logic             rxFromSock_q;
    logic [15:0]      rdata_q;
    logic [1:0]       mode;
    logic             driveP;
    logic             gateR;
    logic             en;
    logic             hostOk;
    logic             txLoad;
    logic             rxDone;
    logic [7:0]       rxByte;
    logic             rxTake;

    assign mode   = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
    assign en     = ctrl_q[CTRL_EN] & link.linkEnable;
    assign driveP = (mode == HS_RTS) | (mode == HS_RTSCTS);
    assign gateR  = (mode == HS_CTS) | (mode == HS_RTSCTS);
    // USB path is the default host; socket wins when connected
    assign hostOk = ~socketConnected | regAddr[ADDR_W-1];
    assign rxTake = regRead & (regAddr == REG_RXDATA) & hostOk;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= CTRL_RESET;
            div_q  <= DIV_DEFAULT;
        end
        else if (regWrite && regAddr == REG_CTRL)
            ctrl_q <= regWdata[2:0];
        else if (regWrite && regAddr == REG_DIV)
        begin
            // Clamp keeps the rate inside the supported span
            if (regWdata > DIV_SLOWEST)
                div_q <= DIV_SLOWEST;
            else if (regWdata < DIV_FASTEST)
                div_q <= DIV_FASTEST;
            else
                div_q <= regWdata;
        end
    end

    // ==================================================================
    // Transmit holding byte
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txHold_q <= 8'h00;
            txFull_q <= 1'b0;
        end
        else if (regWrite && regAddr == REG_TXDATA && !txFull_q && hostOk)
        begin
            txHold_q <= regWdata[7:0];
            txFull_q <= 1'b1;
        end
        else if (txLoad)
            txFull_q <= 1'b0;
    end

    // ==================================================================
    // Receive holding byte, set only while empty; a read clears it and a byte arriving when full is dropped
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxHold_q     <= 8'h00;
            rxFull_q     <= 1'b0;
            rxFromSock_q <= 1'b0;
        end
        else if (rxDone && !rxFull_q)
        begin
            rxHold_q     <= rxByte;
            rxFull_q     <= 1'b1;
            rxFromSock_q <= socketConnected;
        end
        else if (rxTake)
            rxFull_q <= 1'b0;
    end

    // Permit drops as soon as the buffer is full
    assign link.sendPermitOe = driveP;
    assign link.sendPermitN  = rxFull_q | ~en;

    // ==================================================================
    // Serial engines
    vsbfc_uart_tx #(.DIV_WIDTH(DIV_W)) uTx
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .div     (div_q),
        .start   (txFull_q & en & (~gateR | ~link.recvReadyN)),
        .data    (txHold_q),
        .loaded  (txLoad),
        .busy    (),
        .line    (link.targetRx)
    );

    vsbfc_uart_rx #(.DIV_WIDTH(DIV_W)) uRx
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .div     (div_q),
        .enable  (en),
        .line    (link.targetTx),
        .done    (rxDone),
        .data    (rxByte)
    );

    // ==================================================================
    // Read port
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 16'h0000;
        else if (regRead)
        begin
            unique case (regAddr)
                REG_CTRL:   rdata_q <= {13'h0000, ctrl_q};
                REG_DIV:    rdata_q <= div_q;
                REG_STATUS: rdata_q <= {10'h000, socketConnected, ~link.recvReadyN,
                                        ~link.sendPermitN, rxFull_q, txFull_q, txLoad};
                REG_RXDATA: rdata_q <= hostOk ? {8'h00, rxHold_q} : 16'h0000;
                REG_HOST:   rdata_q <= {15'h0000, rxFromSock_q};
                default:    rdata_q <= 16'h0000;
            endcase
        end
        else
            rdata_q <= 16'h0000;
    end
    assign regRdata = rdata_q;
endmodule : vsbfc_bridge

module vsbfc_uart_rx
    import vsbfc_pkg::*;
#(
    parameter int DIV_WIDTH = 16
)
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic [DIV_WIDTH-1:0] div,
    input  wire logic                 enable,
    input  wire logic                 line,
    output logic                      done,
    output logic [7:0]                data
);
    vsb_state_t           st_q;
    logic [DIV_WIDTH-1:0] cnt_q;
    logic [2:0]           n_q;
    logic [7:0]           sh_q;
    logic                 done_q;
    assign done = done_q;
    assign data = sh_q;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q   <= VSB_IDLE;
            cnt_q  <= '0;
            n_q    <= 3'h0;
            sh_q   <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (st_q)
                VSB_IDLE:
                    if (enable && !line)
                    begin
                        st_q  <= VSB_START;
                        cnt_q <= {1'b0, div[DIV_WIDTH-1:1]};
                    end
                VSB_START:
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else if (line)
                        st_q <= VSB_IDLE;
                    else
                    begin
                        st_q  <= VSB_DATA;
                        cnt_q <= div - 1'b1;
                        n_q   <= 3'h0;
                    end
                VSB_DATA:
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                    begin
                        sh_q  <= {line, sh_q[7:1]};
                        cnt_q <= div - 1'b1;
                        n_q   <= n_q + 1'b1;
                        if (n_q == 3'(DATA_BITS - 1))
                            st_q <= VSB_STOP;
                    end
                VSB_STOP:
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                    begin
                        st_q   <= VSB_IDLE;
                        done_q <= line & enable;
                    end
            endcase
        end
    end
endmodule : vsbfc_uart_rx

// ==== logic/vsbfc_target.sv ====
// Target end: UART with optional handshake, plain byte port on the user side
`timescale 1ns/100ps
module vsbfc_target
    import vsbfc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    vsbfc_link_if.target     link,
    input  wire logic [15:0] div,
    input  wire logic        enableLink,
    input  wire logic        honourPermit,
    input  wire logic        readyPinSet,
    input  wire logic [7:0]  txData,
    input  wire logic        txValid,
    output logic             txReady,
    output logic [7:0]       rxData,
    output logic             rxValid,
    input  wire logic        rxReady
);
    logic       txLoad;
    logic       rxDone;
    logic [7:0] rxByte;
    logic [7:0] rxd_q;
    logic       rxv_q;
    logic       en_q;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            en_q <= 1'b0;
        else
            en_q <= enableLink;
    end
    assign link.linkEnable = en_q;
    // Unconfigured ready pin reads not-ready
    assign link.recvReadyN = ~readyPinSet | rxv_q;
    assign txReady = txLoad;

    vsbfc_uart_tx #(.DIV_WIDTH(DIV_W)) uTx
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .div     (div),
        .start   (txValid & (~honourPermit | ~link.sendPermitLineN)),
        .data    (txData),
        .loaded  (txLoad),
        .busy    (),
        .line    (link.targetTx)
    );

    vsbfc_uart_rx #(.DIV_WIDTH(DIV_W)) uRx
    (
        .clock   (clock),
        .arst_n  (arst_n),
        .div     (div),
        .enable  (1'b1),
        .line    (link.targetRx),
        .done    (rxDone),
        .data    (rxByte)
    );

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxd_q <= 8'h00;
            rxv_q <= 1'b0;
        end
        else if (rxDone)
        begin
            rxd_q <= rxByte;
            rxv_q <= 1'b1;
        end
        else if (rxReady)
            rxv_q <= 1'b0;
    end
    assign rxData  = rxd_q;
    assign rxValid = rxv_q;
endmodule : vsbfc_target

module vsbfc_uart_tx
    import vsbfc_pkg::*;
#(
    parameter int DIV_WIDTH = 16
)
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic [DIV_WIDTH-1:0] div,
    input  wire logic                 start,
    input  wire logic [7:0]           data,
    output logic                      loaded,
    output logic                      busy,
    output logic                      line
);
    logic [DIV_WIDTH-1:0] cnt_q;
    logic [3:0]           bit_q;
    logic [9:0]           sh_q;
    logic                 idle;
    assign idle   = (bit_q == BIT_ZERO) && (cnt_q == '0);
    assign loaded = idle & start;
    assign busy   = ~idle;
    assign line   = sh_q[0];

    // Once loaded, a frame runs to its stop bit regardless of handshake
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            bit_q <= BIT_ZERO;
            sh_q  <= 10'h3FF;
        end
        else if (loaded)
        begin
            sh_q  <= {1'b1, data, 1'b0};
            cnt_q <= div - 1'b1;
            bit_q <= BIT_LAST;
        end
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
        else if (bit_q != BIT_ZERO)
        begin
            sh_q  <= {1'b1, sh_q[9:1]};
            bit_q <= bit_q - 1'b1;
            // Stop bit is timed too, so back-to-back frames keep a full stop bit
            cnt_q <= div - 1'b1;
        end
    end
endmodule : vsbfc_uart_tx

// ==== sim/vsbfc_link_sva.sv ====
// Checker: concurrent properties on the serial link between both ends
`timescale 1ns/100ps
module vsbfc_link_sva
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic targetTx,
    input wire logic targetRx,
    input wire logic sendPermitN,
    input wire logic sendPermitOe,
    input wire logic sendPermitLineN,
    input wire logic recvReadyN,
    input wire logic linkEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // Level runs
    // Shortest legal bit is 27 cycles, so any run spans 8 samples
    sequence lowRun(s);
        !s [*8];
    endsequence
    sequence highRun(s);
        s [*8];
    endsequence

    AST_RX_LOW: assert property ($fell(targetRx) |-> lowRun(targetRx))
        else $error("short low run on bridge data line");
    AST_RX_HIGH: assert property ($rose(targetRx) |-> highRun(targetRx))
        else $error("short high run on bridge data line");
    AST_TX_LOW: assert property ($fell(targetTx) |-> lowRun(targetTx))
        else $error("short low run on target data line");
    AST_TX_HIGH: assert property ($rose(targetTx) |-> highRun(targetTx))
        else $error("short high run on target data line");
    AST_RESET_IDLE: assert property ($rose(arst_n) |-> targetRx && targetTx && !sendPermitOe)
        else $error("lines not idle after reset");
    AST_LINE_FREE: assert property (!sendPermitOe |-> sendPermitLineN)
        else $error("undriven permit line not deasserted");
    AST_PERMIT_HOLD: assert property ($rose(sendPermitOe) |-> sendPermitOe [*8])
        else $error("permit drive glitched");
    AST_PERMIT_LEVEL: assert property (!sendPermitLineN |-> linkEnable)
        else $error("permit asserted while link disabled");
endmodule : vsbfc_link_sva

// ==== sim/tb_top.sv ====
// Testbench: both link ends joined, register and byte-port stimulus
`timescale 1ns/100ps
module tb_top
    import vsbfc_pkg::*;
;
    logic        clock;
    logic        arst_n;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic [15:0] regRdata;
    logic [15:0] rdVal;
    logic        regWrite;
    logic        regRead;
    logic        socketConnected;
    logic        enableLink;
    logic [7:0]  txData;
    logic        txValid;
    logic        txReady;
    logic [7:0]  rxData;
    logic        rxValid;
    logic        rxReady;
    logic        honourPermit;
    logic        readyPinSet;
    logic [1:0]  md;
    int          num_errors;
    int          total_checks;

    vsbfc_link_if link ();

    vsbfc_bridge u_vsbfc_bridge
    (
        .clock           (clock),
        .arst_n          (arst_n),
        .link            (link.bridge),
        .regAddr         (regAddr),
        .regWdata        (regWdata),
        .regWrite        (regWrite),
        .regRead         (regRead),
        .regRdata        (regRdata),
        .socketConnected (socketConnected)
    );

    vsbfc_target u_vsbfc_target
    (
        .clock        (clock),
        .arst_n       (arst_n),
        .link         (link.target),
        .div          (DIV_FASTEST),
        .enableLink   (enableLink),
        .honourPermit (honourPermit),
        .readyPinSet  (readyPinSet),
        .txData       (txData),
        .txValid      (txValid),
        .txReady      (txReady),
        .rxData       (rxData),
        .rxValid      (rxValid),
        .rxReady      (rxReady)
    );

    vsbfc_link_sva u_vsbfc_link_sva
    (
        .clock           (clock),
        .arst_n          (arst_n),
        .targetTx        (link.targetTx),
        .targetRx        (link.targetRx),
        .sendPermitN     (link.sendPermitN),
        .sendPermitOe    (link.sendPermitOe),
        .sendPermitLineN (link.sendPermitLineN),
        .recvReadyN      (link.recvReadyN),
        .linkEnable      (link.linkEnable)
    );

    always #20 clock = ~clock;

    // ==========================================
    // Access tasks
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic hang(input string what);
        num_errors++;
        $display("wrong value %s expected done seen timeout", what);
        finish_test();
    endtask : hang

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rdVal = regRdata;
    endtask : rd

    task automatic waitRx(input logic [7:0] exp);
        int n;
        n = 0;
        // One edge first, so a flag cleared on the calling edge is not taken as new
        do
        begin
            @(posedge clock);
            #1 n++;
            if (n > 2000)
                hang("target rx");
        end
        while (rxValid !== 1'b1);
        chk("target byte", {8'h00, exp}, {8'h00, rxData});
    endtask : waitRx

    task automatic ack;
        @(posedge clock);
        rxReady <= 1'b1;
        @(posedge clock);
        rxReady <= 1'b0;
    endtask : ack

    task automatic waitBr;
        int n;
        n = 0;
        rd(REG_STATUS);
        while (rdVal[ST_RXFULL] !== 1'b1)
        begin
            rd(REG_STATUS);
            n++;
            if (n > 1000)
                hang("bridge rx");
        end
    endtask : waitBr

    // Valid already raised: wait for the load, then drop it on that edge
    task automatic txWait;
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
            if (n > 3000)
                hang("target tx");
        end
        while (txReady !== 1'b1);
        @(posedge clock);
        txValid <= 1'b0;
    endtask : txWait

    task automatic tsend(input logic [7:0] b);
        @(posedge clock);
        txData  <= b;
        txValid <= 1'b1;
        txWait();
    endtask : tsend

    // ==========================================
    // Main sequence
    initial
    begin
        clock = 1'b0;
        arst_n = 1'b0;
        regAddr = REG_CTRL;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        socketConnected = 1'b0;
        enableLink = 1'b0;
        txData = 8'h00;
        txValid = 1'b0;
        rxReady = 1'b0;
        honourPermit = 1'b0;
        readyPinSet = 1'b1;
        num_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rd(REG_CTRL);
        chk("ctrl", 16'h0000, rdVal);
        rd(REG_DIV);
        chk("div", DIV_DEFAULT, rdVal);
        chk("permit oe", 16'h0000, {15'h0, link.sendPermitOe});
        wr(REG_DIV, 16'h0005);
        rd(REG_DIV);
        chk("div low", DIV_FASTEST, rdVal);
        wr(REG_DIV, 16'hFFFF);
        rd(REG_DIV);
        chk("div high", 16'h0A2C, rdVal);
        wr(REG_DIV, DIV_FASTEST);
        rd(4'hF);
        chk("unmapped", 16'h0000, rdVal);
        wr(REG_CTRL, 16'h0004);
        wr(REG_TXDATA, 16'h005A);
        repeat (600) @(posedge clock);
        chk("rx while off", 16'h0000, {15'h0, rxValid});
        enableLink <= 1'b1;
        waitRx(8'h5A);
        ack();
        for (int m = 0; m < 4; m++)
        begin
            md = 2'(m);
            wr(REG_CTRL, 16'h0004 | {14'h0, md});
            // Target honours the permit line only where the bridge drives it
            honourPermit <= md[0];
            rd(REG_STATUS);
            chk("permit oe", {15'h0, md[0]}, {15'h0, link.sendPermitOe});
            chk("permit line", {15'h0, ~md[0]}, {15'h0, link.sendPermitLineN});
            wr(REG_TXDATA, {8'h00, 8'hC0 + 8'(m)});
            waitRx(8'hC0 + 8'(m));
            // Target now holds a byte, so it has dropped ready
            wr(REG_TXDATA, {8'h00, 8'h30 + 8'(m)});
            repeat (600) @(posedge clock);
            rd(REG_STATUS);
            chk("tx held", {15'h0, md[1]}, {15'h0, rdVal[ST_TXFULL]});
            ack();
            if (md[1])
            begin
                waitRx(8'h30 + 8'(m));
                ack();
            end
            tsend(8'h60 + 8'(m));
            waitBr();
            chk("permit flag", 16'h0000, {15'h0, rdVal[ST_PERMIT]});
            chk("permit full", 16'h0001, {15'h0, link.sendPermitLineN});
            rd(REG_RXDATA);
            chk("bridge byte", {8'h00, 8'h60 + 8'(m)}, rdVal);
            rd(REG_STATUS);
            chk("permit free", {15'h0, ~md[0]}, {15'h0, link.sendPermitLineN});
        end
        // Bridge full in rtscts mode: the target must hold its next byte
        tsend(8'h41);
        waitBr();
        @(posedge clock);
        txData  <= 8'h42;
        txValid <= 1'b1;
        repeat (400)
        begin
            @(negedge clock);
            chk("target paused", 16'h0000, {15'h0, txReady});
        end
        rd(REG_RXDATA);
        chk("first byte", 16'h0041, rdVal);
        txWait();
        waitBr();
        rd(REG_RXDATA);
        chk("held byte", 16'h0042, rdVal);
        // Unset ready pin keeps the bridge's byte back
        @(posedge clock);
        readyPinSet <= 1'b0;
        wr(REG_TXDATA, 16'h0055);
        repeat (600) @(posedge clock);
        rd(REG_STATUS);
        chk("no ready", 16'h0002, {14'h0, rdVal[ST_TXFULL], rdVal[ST_READY]});
        @(posedge clock);
        readyPinSet <= 1'b1;
        waitRx(8'h55);
        ack();
        wr(REG_CTRL, 16'h0004);
        honourPermit <= 1'b0;
        socketConnected <= 1'b1;
        tsend(8'h77);
        waitBr();
        chk("socket flag", 16'h0001, {15'h0, rdVal[ST_SOCKET]});
        rd(REG_RXDATA);
        chk("usb blocked", 16'h0000, rdVal);
        rd(REG_HOST);
        chk("host path", 16'h0001, {15'h0, rdVal[0]});
        finish_test();
    end
endmodule : tb_top
